// ---- logic/cac_capture_compare.sv ----
/*
 capture/compare modules of the counter array: mode decode, pin
 synchronising and filtering, edge capture, flags, interrupt request,
 pwm length and overflow interrupt, comparator gating of the module outputs.
 assumes a free-running 16-bit counter and its comparator match pulses come
 from outside; the register port is byte wide with read data one cycle later.
 software clears flags by writing zero to their bits; external pins must hold
 each level for two clocks or the edge may be missed.
*/
`timescale 1ns/1ps
module cac_capture_compare #(
	parameter int MODULES = cac_pkg::MODULES
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           regAddr,
	input  wire logic [7:0]           regWriteData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic      [7:0]           regReadData,
	input  wire logic [15:0]          arrayCount,
	input  wire logic [MODULES-1:0]   compareMatch,
	input  wire logic [MODULES-1:0]   moduleToggleReq,
	input  wire logic [MODULES-1:0]   pwmLevelReq,
	input  wire logic [MODULES-1:0]   module_capture_pin,
	output logic      [MODULES-1:0]   moduleOutput,
	output logic      [MODULES-1:0]   comparatorOn,
	output logic      [MODULES-1:0]   pwmGroupMember,
	output logic      [3:0]           pwmCycleBits,
	output logic      [MODULES-1:0]   usesReloadReg,
	output logic                      counterArrayIrq
);
	typedef struct packed {
		logic [MODULES-1:0][7:0]  module_mode_reg;
		logic [MODULES-1:0][15:0] moduleValue;
		logic [MODULES-1:0][15:0] reloadValue;
		logic [MODULES-1:0]       module_event_flag;
		logic [7:0]               pwm_global_config_reg;
		logic [MODULES-1:0]       syncA;
		logic [MODULES-1:0]       syncB;
		logic [MODULES-1:0]       syncC;
		logic [MODULES-1:0]       stableLevel;
		logic [MODULES-1:0]       outLevel;
		logic [15:0]              prevCount;
		logic [7:0]               readData;
	} cac_state_type;

	cac_state_type state;
	cac_state_type next_state;

	function automatic cac_pkg::cac_mode_type decode_mode(input logic [7:0] m);
		cac_pkg::cac_mode_type res;
		res = cac_pkg::CAC_RESERVED;
		if (m[3:1] == 3'b000)
		begin
			res = cac_pkg::CAC_CAPTURE;
		end
		else if (m[3:1] == 3'b100)
		begin
			res = cac_pkg::CAC_SWTIMER;
		end
		else if (m[3:1] == 3'b110)
		begin
			res = cac_pkg::CAC_HSOUT;
		end
		else if (m[3:1] == 3'b011)
		begin
			res = cac_pkg::CAC_FREQOUT;
		end
		else if (m[1] && !m[2])
		begin
			res = m[cac_pkg::MODE_PWM16] ? cac_pkg::CAC_PWM16 : cac_pkg::CAC_PWM8_11;
		end
		return res;
	endfunction

	function automatic logic overflow_at(input logic [15:0] prev, input logic [15:0] cur,
		input logic [1:0] len);
		logic [3:0] topBit;
		logic       wasSet;
		logic       nowSet;
		topBit = 4'h7 + {2'b00, len};
		wasSet = prev[topBit];
		nowSet = cur[topBit];
		// a falling top bit means the count wrapped past the chosen length
		return wasSet && !nowSet;
	endfunction

	// per-module registers sit at a base plus the module index
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] base,
		input int idx);
		logic [7:0] target;
		target = base + 8'(idx);
		return addr == target;
	endfunction

	// 8-bit pwm has no reload register, so steering needs a length above 8
	function automatic logic reload_steered(input logic [7:0] cfg,
		input cac_pkg::cac_mode_type mode);
		logic longPwm;
		longPwm = cfg[cac_pkg::CFG_LEN_LSB +: 2] != 2'b00;
		return cfg[cac_pkg::CFG_RELOAD_SEL] && longPwm && mode == cac_pkg::CAC_PWM8_11;
	endfunction

	cac_pkg::cac_mode_type modeOf [MODULES];
	logic [MODULES-1:0] isCapture;
	logic [MODULES-1:0] isPwm;
	logic [MODULES-1:0] riseSeen;
	logic [MODULES-1:0] fallSeen;
	logic [MODULES-1:0] captureNow;

	genvar g;
	generate
		for (g = 0; g < MODULES; g++)
		begin : gen_mod
			always_comb
			begin
				modeOf[g] = decode_mode(state.module_mode_reg[g]);
				isCapture[g] = modeOf[g] == cac_pkg::CAC_CAPTURE;
				isPwm[g] = modeOf[g] == cac_pkg::CAC_PWM8_11 || modeOf[g] == cac_pkg::CAC_PWM16;
				// syncB and syncC agreeing for a new level means two stable clocks
				riseSeen[g] = state.syncB[g] && state.syncC[g] && !state.stableLevel[g];
				fallSeen[g] = !state.syncB[g] && !state.syncC[g] && state.stableLevel[g];
				// pulses shorter than the filter never reach this point
				captureNow[g] = 1'b0;
				if (isCapture[g])
				begin
					captureNow[g] =
						(riseSeen[g] && state.module_mode_reg[g][cac_pkg::MODE_RISE_EN]) ||
						(fallSeen[g] && state.module_mode_reg[g][cac_pkg::MODE_FALL_EN]);
				end
			end
		end
	endgenerate

	logic       pwmOverflow;
	logic       steerNow;

	always_comb
	begin
		next_state = state;
		pwmOverflow = overflow_at(state.prevCount, arrayCount,
			state.pwm_global_config_reg[cac_pkg::CFG_LEN_LSB +: 2]);
		steerNow = 1'b0;
		next_state.syncA = module_capture_pin;
		next_state.syncB = state.syncA;
		next_state.syncC = state.syncB;
		next_state.prevCount = arrayCount;
		next_state.readData = 8'h00;

		for (int i = 0; i < MODULES; i++)
		begin
			// a level must get through the filter before the stable copy moves
			if (riseSeen[i])
			begin
				next_state.stableLevel[i] = 1'b1;
			end
			else if (fallSeen[i])
			begin
				next_state.stableLevel[i] = 1'b0;
			end
			// comparator off forces the output low in every mode
			if (!state.module_mode_reg[i][cac_pkg::MODE_CMP_EN])
			begin
				next_state.outLevel[i] = 1'b0;
			end
			else if (isPwm[i])
			begin
				next_state.outLevel[i] = pwmLevelReq[i];
			end
			else if (modeOf[i] == cac_pkg::CAC_HSOUT || modeOf[i] == cac_pkg::CAC_FREQOUT)
			begin
				next_state.outLevel[i] = state.outLevel[i] ^ moduleToggleReq[i];
			end
		end

		// software first: hardware set below overrides a same-cycle clear
		if (regWrite)
		begin
			for (int i = 0; i < MODULES; i++)
			begin
				// steering follows the config in force before this write
				steerNow = reload_steered(state.pwm_global_config_reg, modeOf[i]);
				if (reg_hit(regAddr, cac_pkg::OFF_MODE_BASE, i))
				begin
					next_state.module_mode_reg[i] = regWriteData;
				end
				if (reg_hit(regAddr, cac_pkg::OFF_VLOW_BASE, i))
				begin
					if (steerNow)
					begin
						next_state.reloadValue[i][7:0] = regWriteData;
					end
					else
					begin
						next_state.moduleValue[i][7:0] = regWriteData;
					end
				end
				if (reg_hit(regAddr, cac_pkg::OFF_VHIGH_BASE, i))
				begin
					if (steerNow)
					begin
						next_state.reloadValue[i][15:8] = regWriteData;
					end
					else
					begin
						next_state.moduleValue[i][15:8] = regWriteData;
					end
				end
			end
			if (regAddr == cac_pkg::OFF_PWM_CFG)
			begin
				next_state.pwm_global_config_reg = regWriteData;
				// overflow flag only clears by writing zero, never sets from software
				next_state.pwm_global_config_reg[cac_pkg::CFG_OVF_FLAG] =
					state.pwm_global_config_reg[cac_pkg::CFG_OVF_FLAG] &
					regWriteData[cac_pkg::CFG_OVF_FLAG];
			end
			if (regAddr == cac_pkg::OFF_FLAGS)
			begin
				next_state.module_event_flag = state.module_event_flag &
					regWriteData[MODULES-1:0];
			end
		end

		for (int i = 0; i < MODULES; i++)
		begin
			if (captureNow[i])
			begin
				next_state.moduleValue[i] = arrayCount;
				next_state.module_event_flag[i] = 1'b1;
			end
			if (isPwm[i] && state.module_mode_reg[i][cac_pkg::MODE_MATCH_EN] &&
				state.module_mode_reg[i][cac_pkg::MODE_CMP_EN] && compareMatch[i])
			begin
				next_state.module_event_flag[i] = 1'b1;
			end
		end
		if (pwmOverflow)
		begin
			next_state.pwm_global_config_reg[cac_pkg::CFG_OVF_FLAG] = 1'b1;
		end

		// only strobed reads show data; idle cycles read as zero
		if (regRead)
		begin
			for (int i = 0; i < MODULES; i++)
			begin
				steerNow = reload_steered(state.pwm_global_config_reg, modeOf[i]);
				if (reg_hit(regAddr, cac_pkg::OFF_MODE_BASE, i))
				begin
					next_state.readData = state.module_mode_reg[i];
				end
				if (reg_hit(regAddr, cac_pkg::OFF_VLOW_BASE, i))
				begin
					next_state.readData = steerNow ?
						state.reloadValue[i][7:0] : state.moduleValue[i][7:0];
				end
				if (reg_hit(regAddr, cac_pkg::OFF_VHIGH_BASE, i))
				begin
					next_state.readData = steerNow ?
						state.reloadValue[i][15:8] : state.moduleValue[i][15:8];
				end
			end
			if (regAddr == cac_pkg::OFF_PWM_CFG)
			begin
				next_state.readData = state.pwm_global_config_reg;
			end
			if (regAddr == cac_pkg::OFF_FLAGS)
			begin
				next_state.readData = 8'(state.module_event_flag);
			end
			if (regAddr == cac_pkg::OFF_PIN_LEVEL)
			begin
				next_state.readData = 8'(state.stableLevel);
			end
			if (regAddr == cac_pkg::OFF_COUNT_LOW)
			begin
				next_state.readData = arrayCount[7:0];
			end
			if (regAddr == cac_pkg::OFF_COUNT_HIGH)
			begin
				next_state.readData = arrayCount[15:8];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state.module_mode_reg <= '{default: cac_pkg::MODE_RESET};
			state.moduleValue <= '{default: cac_pkg::VALUE_RESET};
			state.reloadValue <= '{default: cac_pkg::VALUE_RESET};
			state.module_event_flag <= '0;
			state.pwm_global_config_reg <= cac_pkg::CFG_RESET;
			state.syncA <= '0;
			state.syncB <= '0;
			state.syncC <= '0;
			state.stableLevel <= '0;
			state.outLevel <= '0;
			state.prevCount <= 16'h0000;
			state.readData <= 8'h00;
		end
		else
		begin
			state <= next_state;
		end
	end

	always_comb
	begin
		regReadData = state.readData;
		moduleOutput = state.outLevel;
		pwmCycleBits = 4'h8 + {2'b00, state.pwm_global_config_reg[cac_pkg::CFG_LEN_LSB +: 2]};
		// overflow source first; any enabled module flag then pulls the line up
		counterArrayIrq = state.pwm_global_config_reg[cac_pkg::CFG_OVF_IRQ_EN] &
			state.pwm_global_config_reg[cac_pkg::CFG_OVF_FLAG];
		for (int i = 0; i < MODULES; i++)
		begin
			comparatorOn[i] = state.module_mode_reg[i][cac_pkg::MODE_CMP_EN];
			pwmGroupMember[i] = modeOf[i] == cac_pkg::CAC_PWM8_11;
			usesReloadReg[i] = pwmGroupMember[i] &&
				state.pwm_global_config_reg[cac_pkg::CFG_LEN_LSB +: 2] != 2'b00;
			if (state.module_event_flag[i] && state.module_mode_reg[i][cac_pkg::MODE_IRQ_EN])
			begin
				counterArrayIrq = 1'b1;
			end
		end
	end
endmodule

// ---- logic/cac_pkg.sv ----
/*
 pkg for the counter array capture/compare block: register offsets, field
 positions, reset values and mode encodings.
 assumes a byte-wide register port; used by logic/cac_capture_compare.sv.
*/
package cac_pkg;
	localparam int MODULES = 5;

	// register offsets: per-module register = base + module index
	localparam logic [7:0] OFF_MODE_BASE  = 8'h00;
	localparam logic [7:0] OFF_VLOW_BASE  = 8'h10;
	localparam logic [7:0] OFF_VHIGH_BASE = 8'h20;
	localparam logic [7:0] OFF_PWM_CFG    = 8'h30;
	localparam logic [7:0] OFF_FLAGS      = 8'h31;
	localparam logic [7:0] OFF_PIN_LEVEL  = 8'h32;
	localparam logic [7:0] OFF_COUNT_LOW  = 8'h33;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h34;

	// module_mode_reg fields
	localparam int MODE_IRQ_EN   = 0;
	localparam int MODE_MATCH_EN = 3;
	localparam int MODE_FALL_EN  = 4;
	localparam int MODE_RISE_EN  = 5;
	localparam int MODE_CMP_EN   = 6;
	localparam int MODE_PWM16    = 7;

	// pwm_global_config_reg fields
	localparam int CFG_LEN_LSB    = 0;
	localparam int CFG_OVF_IRQ_EN = 5;
	localparam int CFG_OVF_FLAG   = 6;
	localparam int CFG_RELOAD_SEL = 7;

	localparam logic [7:0]  MODE_RESET = 8'h00;
	localparam logic [7:0]  CFG_RESET  = 8'h00;
	localparam logic [15:0] VALUE_RESET = 16'h0000;

	// a level counts after this many stable cycles
	localparam int STABLE_CYCLES = 2;

	typedef enum logic [6:0] {
		CAC_CAPTURE  = 7'b000_0001,
		CAC_SWTIMER  = 7'b000_0010,
		CAC_HSOUT    = 7'b000_0100,
		CAC_FREQOUT  = 7'b000_1000,
		CAC_PWM8_11  = 7'b001_0000,
		CAC_PWM16    = 7'b010_0000,
		CAC_RESERVED = 7'b100_0000
	} cac_mode_type;
endpackage

// ---- dv/cac_capture_compare_props.sv ----
/* property checker for the capture/compare block.
 assumes only the top ports, one clock and an active-high reset. */
`timescale 1ns/1ps
module cac_capture_compare_props #(
	parameter int MODULES = 5
) (
	input wire logic               sys_clk,
	input wire logic               rst,
	input wire logic [7:0]         regAddr,
	input wire logic [7:0]         regWriteData,
	input wire logic               regWrite,
	input wire logic               regRead,
	input wire logic [7:0]         regReadData,
	input wire logic [15:0]        arrayCount,
	input wire logic [MODULES-1:0] moduleOutput,
	input wire logic [MODULES-1:0] comparatorOn,
	input wire logic [MODULES-1:0] pwmGroupMember,
	input wire logic [3:0]         pwmCycleBits,
	input wire logic [MODULES-1:0] usesReloadReg,
	input wire logic               counterArrayIrq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_cfg_wr;
		regWrite && regAddr == cac_pkg::OFF_PWM_CFG;
	endsequence
	sequence s_mode0_wr;
		regWrite && regAddr == cac_pkg::OFF_MODE_BASE;
	endsequence
	property p_len; s_cfg_wr |=> pwmCycleBits == 4'h8 + $past(regWriteData[1:0]); endproperty
	a_len: assert property (p_len) else $error("pwm length wrong after config write");
	property p_range; pwmCycleBits >= 4'h8 && pwmCycleBits <= 4'hB; endproperty
	a_range: assert property (p_range) else $error("pwm length out of range");
	property p_member; s_mode0_wr |=> pwmGroupMember[0] ==
		(!$past(regWriteData[7]) && $past(regWriteData[2:1]) == 2'b01); endproperty
	a_member: assert property (p_member) else $error("pwm group decode wrong");
	property p_cmp; s_mode0_wr |=> comparatorOn[0] == $past(regWriteData[6]); endproperty
	a_cmp: assert property (p_cmp) else $error("comparator enable wrong");
	property p_off; (moduleOutput & ~comparatorOn & ~$past(comparatorOn)) == '0; endproperty
	a_off: assert property (p_off) else $error("output high with comparator off");
	property p_reload; (usesReloadReg & ~pwmGroupMember) == '0; endproperty
	a_reload: assert property (p_reload) else $error("reload steering outside pwm group");
	property p_irq_hold; counterArrayIrq && !regWrite |=> counterArrayIrq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without write");
	property p_rd_idle; !regRead |=> regReadData == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_rd_cnt; regRead && regAddr == cac_pkg::OFF_COUNT_LOW
		|=> regReadData == $past(arrayCount[7:0]); endproperty
	a_rd_cnt: assert property (p_rd_cnt) else $error("counter low read wrong");
endmodule
bind cac_capture_compare cac_capture_compare_props #(.MODULES(MODULES)) props_u (
	.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
	.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
	.arrayCount(arrayCount), .moduleOutput(moduleOutput), .comparatorOn(comparatorOn),
	.pwmGroupMember(pwmGroupMember), .pwmCycleBits(pwmCycleBits),
	.usesReloadReg(usesReloadReg), .counterArrayIrq(counterArrayIrq));

// ---- dv/cac_pin_partner.sv ----
/* external driver of the capture pins.
 assumes the bench asks for levels; a new one waits for the minimum hold. */
`timescale 1ns/1ps
module cac_pin_partner #(
	parameter int MODULES = 5
) (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic [MODULES-1:0] wantLevel,
	output logic      [MODULES-1:0] pinLevel
);
	int heldCycles [MODULES];
	always_ff @(posedge sys_clk or posedge rst)
	begin
		for (int i = 0; i < MODULES; i++)
		begin
			if (rst)
			begin
				pinLevel[i] <= 1'b0;
				heldCycles[i] <= 0;
			end
			else if (heldCycles[i] < cac_pkg::STABLE_CYCLES)
				heldCycles[i] <= heldCycles[i] + 1;
			else if (wantLevel[i] != pinLevel[i])
			begin
				pinLevel[i] <= wantLevel[i];
				heldCycles[i] <= 1;
			end
		end
	end
endmodule

// ---- dv/cac_tb_top.sv ----
/* bench for the capture/compare block: register tasks and scenario sequence.
 assumes the pin partner and the bound checker. */
`timescale 1ns/1ps
module tb_top;
	localparam int M = cac_pkg::MODULES;
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	logic [7:0]   regAddr = 8'h00;
	logic [7:0]   regWriteData = 8'h00;
	logic         regWrite = 1'b0;
	logic         regRead = 1'b0;
	logic [15:0]  arrayCount = 16'h0000;
	logic [M-1:0] compareMatch = '0;
	logic [M-1:0] pwmLevelReq = '0;
	logic [M-1:0] wantLevel = '0;
	logic [M-1:0] toggleReq = '0;
	logic [M-1:0] pin, moduleOutput, comparatorOn, pwmGroupMember, usesReloadReg;
	logic [7:0]   regReadData, d;
	logic [3:0]   pwmCycleBits;
	logic         counterArrayIrq;
	logic [15:0]  cap, c0;
	logic [7:0]   modeTab [6] = '{8'h20, 8'h48, 8'h4C, 8'h46, 8'h4A, 8'hC2};
	int           errTotal = 0;
	int           nChecks = 0;
	int           k;
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) arrayCount <= arrayCount + 16'h0001;
	cac_capture_compare #(.MODULES(M)) dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData), .arrayCount(arrayCount), .compareMatch(compareMatch),
		.moduleToggleReq(toggleReq), .pwmLevelReq(pwmLevelReq), .module_capture_pin(pin),
		.moduleOutput(moduleOutput), .comparatorOn(comparatorOn),
		.pwmGroupMember(pwmGroupMember), .pwmCycleBits(pwmCycleBits),
		.usesReloadReg(usesReloadReg), .counterArrayIrq(counterArrayIrq));
	cac_pin_partner #(.MODULES(M)) pin_u (.sys_clk(sys_clk), .rst(rst),
		.wantLevel(wantLevel), .pinLevel(pin));
	task automatic end_sim();
		if (errTotal == 0 && nChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		nChecks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= v;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	// read data stand only in the slot after the strobe, so sample just inside it
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 v = regReadData;
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && counterArrayIrq !== 1'b1; i++)
			@(posedge sys_clk) #1;
		chk("irq", 16'h0001, counterArrayIrq);
		if (counterArrayIrq !== 1'b1)
			end_sim();
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 chk("cycle bits", 16'h0008, pwmCycleBits);
		rd(cac_pkg::OFF_MODE_BASE + 8'h02, d);
		chk("mode reset", cac_pkg::MODE_RESET, d);
		rd(8'hFF, d);
		chk("unmapped", 16'h0000, d);
		rd(cac_pkg::OFF_COUNT_LOW, d);
		chk("count low", 16'(8'(arrayCount[7:0] - 8'h01)), d);
		wr(cac_pkg::OFF_MODE_BASE, 8'h42);
		wr(cac_pkg::OFF_MODE_BASE + 8'h01, 8'h42);
		for (k = 0; k < 4; k++)
		begin
			wr(cac_pkg::OFF_PWM_CFG, 8'h80 | 8'(k));
			#1 chk("cycle bits", 16'(8 + k), pwmCycleBits);
		end
		chk("group", 16'h0003, pwmGroupMember);
		chk("reload", 16'h0003, usesReloadReg);
		wr(cac_pkg::OFF_VLOW_BASE, 8'h5A);
		wr(cac_pkg::OFF_PWM_CFG, 8'h80);
		rd(cac_pkg::OFF_VLOW_BASE, d);
		chk("8-bit value low", 16'h0000, d);
		wr(cac_pkg::OFF_PWM_CFG, 8'h81);
		rd(cac_pkg::OFF_VLOW_BASE, d);
		chk("reload low", 16'h005A, d);
		pwmLevelReq <= '1;
		repeat (3) @(posedge sys_clk);
		#1 chk("pwm out", 16'h0003, moduleOutput);
		wr(cac_pkg::OFF_MODE_BASE, 8'h02);
		repeat (3) @(posedge sys_clk);
		#1 chk("pwm out off", 16'h0002, moduleOutput);
		pwmLevelReq <= '0;
		for (k = 0; k < 6; k++)
		begin
			wr(cac_pkg::OFF_MODE_BASE, modeTab[k]);
			#1 chk("member", 16'(k == 4), pwmGroupMember[0]);
			chk("comparator", 16'(modeTab[k][6]), comparatorOn[0]);
		end
		wr(cac_pkg::OFF_MODE_BASE + 8'h04, 8'h0C);
		toggleReq[4] <= 1'b1;
		@(posedge sys_clk);
		toggleReq[4] <= 1'b0;
		#1 chk("hs still", 16'h0000, moduleOutput[4]);
		wr(cac_pkg::OFF_MODE_BASE + 8'h04, 8'h4C);
		toggleReq[4] <= 1'b1;
		@(posedge sys_clk);
		toggleReq[4] <= 1'b0;
		#1 chk("hs toggle", 16'h0001, moduleOutput[4]);
		wr(cac_pkg::OFF_PWM_CFG, 8'h00);
		wr(cac_pkg::OFF_MODE_BASE + 8'h02, 8'h21);
		wantLevel[2] <= 1'b1;
		#1 c0 = arrayCount;
		wait_irq(12);
		rd(cac_pkg::OFF_VLOW_BASE + 8'h02, cap[7:0]);
		rd(cac_pkg::OFF_VHIGH_BASE + 8'h02, cap[15:8]);
		chk("capture window", 16'(cap != c0 && 16'(cap - c0) <= 16'h0008), 16'h0001);
		rd(cac_pkg::OFF_FLAGS, d);
		rd(cac_pkg::OFF_FLAGS, d);
		chk("flags", 16'h0004, d);
		rd(cac_pkg::OFF_PIN_LEVEL, d);
		chk("pin level", 16'h0001, d[2]);
		wantLevel[2] <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(cac_pkg::OFF_VLOW_BASE + 8'h02, d);
		chk("no fall capture", cap[7:0], d);
		wr(cac_pkg::OFF_FLAGS, 8'h1B);
		#1 chk("irq cleared", 16'h0000, counterArrayIrq);
		wr(cac_pkg::OFF_MODE_BASE + 8'h02, 8'h30);
		wantLevel[2] <= 1'b1;
		repeat (8) @(posedge sys_clk);
		wr(cac_pkg::OFF_FLAGS, 8'h00);
		wantLevel[2] <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(cac_pkg::OFF_FLAGS, d);
		chk("fall flag", 16'h0004, d);
		chk("irq masked", 16'h0000, counterArrayIrq);
		wr(cac_pkg::OFF_FLAGS, 8'h00);
		wr(cac_pkg::OFF_MODE_BASE + 8'h03, 8'h4A);
		compareMatch[3] <= 1'b1;
		@(posedge sys_clk);
		compareMatch[3] <= 1'b0;
		rd(cac_pkg::OFF_FLAGS, d);
		chk("match flag", 16'h0008, d);
		wr(cac_pkg::OFF_FLAGS, 8'h00);
		wr(cac_pkg::OFF_PWM_CFG, 8'h20);
		wait_irq(300);
		rd(cac_pkg::OFF_PWM_CFG, d);
		chk("overflow flag", 16'h0060, d);
		end_sim();
	end
endmodule
